//--- logic/gptcp_timer.sv
// 64-bit timer counter, period compare and output control with a wishbone slave
// assumes timer pin and gate input are asynchronous; rst_i is the hardware reset
//
// Functional notes
// - count is four 16-bit words, each at its own address.
// - general mode advances count by one per enabled tick; reset clears it.
// - continuous run loads zero one tick after count equals period.
// - dual modes split count into low and high 32-bit pairs.
// - hardware reset clears all count words; half resets leave them.
// - a half held in reset keeps its count pair value.
// - a count pair acts as a 32-bit counter in dual modes.
// - 64-bit modes compare all four period words together.
// - dual modes compare each period pair with its count pair.
// - second control word applies only in dual independent mode.
// - gate bit with internal clock counts only while input is high.
// - clock-source bit picks internal clock or timer pin edges.
// - disabled run holds count; one-time run wraps to zero at period, then stops.
// - pulse width is one to four ticks from the width field.
// - pulse style emits one pulse at period match, invert-controlled.
// - clock style toggles output level at each period match.
// - watchdog mode forces pulse style output.
// - input invert applies only with the pin clock source.
// - output invert bit inverts the presented output.
// - read-only status bit shows output level and drives pin.
// - status bit freezes while the pin is in gpio use.
// - upper control bits read zero and ignore writes.
// - mode field decodes gp64, dual independent, watchdog, dual chained.
// - lower half in reset clears status and floats the output.
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`include "gptcp_map.svh"
module gptcp_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tmr_pin_i,
  input wire logic gate_pin_i,
  input wire logic gpio_use_i,
  output logic tmr_out_o,
  output logic tmr_oe_o
);
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] count_word [4];
  logic [15:0] period_word [4];
  logic [15:0] timer_control_low;
  logic [15:0] timer_control_high;
  logic [15:0] global_control_word;
  logic stat_lo;
  logic stat_hi;
  logic [2:0] pw_lo;
  logic [2:0] pw_hi;
  logic [1:0] pin_sync;
  logic [1:0] gate_sync;
  logic pin_prev;
  logic gate_prev;
  logic done_lo;
  logic done_hi;

  gptcp_pkg::gptcp_mode_t opmode;
  logic dual;
  logic lower_half_run_bit;
  logic upper_half_run_bit;
  logic [15:0] ctl_hi_eff;
  logic wr;
  logic [63:0] cnt64;
  logic [63:0] prd64;

  assign opmode = gptcp_pkg::gptcp_mode_t'(global_control_word[`GPTCP_B_MODE +: 2]);
  assign dual = (opmode == gptcp_pkg::GPTCP_MODE_DUAL_IND) || (opmode == gptcp_pkg::GPTCP_MODE_DUAL_CHN);
  assign lower_half_run_bit = global_control_word[`GPTCP_B_LRUN];
  assign upper_half_run_bit = global_control_word[`GPTCP_B_URUN];
  // second control word only when independent
  assign ctl_hi_eff = (opmode == gptcp_pkg::GPTCP_MODE_DUAL_IND) ? timer_control_high : timer_control_low;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_sel_i[1];
  assign cnt64 = {count_word[3], count_word[2], count_word[1], count_word[0]};
  assign prd64 = {period_word[3], period_word[2], period_word[1], period_word[0]};

  // ****************************************
  // input synchronisers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sync <= 2'h0;
      gate_sync <= 2'h0;
      pin_prev <= 1'b0;
      gate_prev <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[0], tmr_pin_i};
      gate_sync <= {gate_sync[0], gate_pin_i};
      pin_prev <= pin_sync[1];
      gate_prev <= gate_sync[1];
    end
  end

  // ****************************************
  // tick generation, one per half
  // ****************************************
  function automatic logic tick_of(input logic [15:0] ctl, input logic pin, input logic pinp, input logic gate);
    logic p;
    logic pp;
    p = pin;
    pp = pinp;
    if (ctl[`GPTCP_B_INV_IN]) begin
      p = !pin;
      pp = !pinp;
    end
    if (ctl[`GPTCP_B_CSRC]) begin
      tick_of = p && !pp;
    end else begin
      tick_of = ctl[`GPTCP_B_GATE] ? gate : 1'b1;
    end
  endfunction : tick_of

  logic tick_lo;
  logic tick_hi;
  logic run_lo;
  logic run_hi;
  logic match_lo;
  logic match_hi;
  logic match64;
  logic adv_lo;
  logic adv_hi;
  logic adv64;
  logic [31:0] next_cnt_lo;
  logic [31:0] next_cnt_hi;
  logic [63:0] next_cnt64;
  logic carry_hi;

  assign tick_lo = tick_of(timer_control_low, pin_sync[1], pin_prev, gate_sync[1]);
  assign tick_hi = tick_of(ctl_hi_eff, pin_sync[1], pin_prev, gate_sync[1]);
  // disabled holds, one-time stops after match
  assign run_lo = (timer_control_low[`GPTCP_B_RUN +: 2] == gptcp_pkg::GPTCP_RUN_CONT)
    || ((timer_control_low[`GPTCP_B_RUN +: 2] == gptcp_pkg::GPTCP_RUN_ONCE) && !done_lo);
  assign run_hi = (ctl_hi_eff[`GPTCP_B_RUN +: 2] == gptcp_pkg::GPTCP_RUN_CONT)
    || ((ctl_hi_eff[`GPTCP_B_RUN +: 2] == gptcp_pkg::GPTCP_RUN_ONCE) && !done_hi);
  assign match64 = (cnt64 == prd64);
  assign match_lo = ({count_word[1], count_word[0]} == {period_word[1], period_word[0]});
  assign match_hi = ({count_word[3], count_word[2]} == {period_word[3], period_word[2]});
  // a half in reset does not advance
  assign adv64 = !dual && lower_half_run_bit && upper_half_run_bit && run_lo && tick_lo;
  assign adv_lo = dual && lower_half_run_bit && run_lo && tick_lo;
  // chained: low pair acts as prescaler for the high pair
  assign carry_hi = (opmode == gptcp_pkg::GPTCP_MODE_DUAL_CHN) ? (adv_lo && match_lo) : tick_hi;
  assign adv_hi = dual && upper_half_run_bit && run_hi && carry_hi;
  // wrap to zero after the match tick
  assign next_cnt64 = match64 ? 64'h0 : cnt64 + 64'h1;
  // each pair is its own 32-bit counter
  assign next_cnt_lo = match_lo ? 32'h0 : {count_word[1], count_word[0]} + 32'h1;
  assign next_cnt_hi = match_hi ? 32'h0 : {count_word[3], count_word[2]} + 32'h1;

  // ****************************************
  // count words
  // ****************************************
  always_ff @(posedge clk_i) begin
    // hardware reset clears all count words
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        count_word[i] <= 16'h0000;
      end
    end else begin
      // advance the 64-bit count per tick
      if (adv64) begin
        {count_word[3], count_word[2], count_word[1], count_word[0]} <= next_cnt64;
      end
      // pairs run separately in dual modes
      if (adv_lo) begin
        {count_word[1], count_word[0]} <= next_cnt_lo;
      end
      if (adv_hi) begin
        {count_word[3], count_word[2]} <= next_cnt_hi;
      end
      // each word writable at its own address
      if (wr) begin
        for (int i = 0; i < 4; i++) begin
          if (wb_adr_i == (`GPTCP_OFS_COUNT0 + 8'(4 * i))) begin
            count_word[i] <= wb_dat_i[15:0];
          end
        end
      end
    end
  end

  // ****************************************
  // one-time completion flags
  // ****************************************
  logic ev_lo;
  logic ev_hi;
  assign ev_lo = dual ? (adv_lo && match_lo) : (adv64 && match64);
  assign ev_hi = dual ? (adv_hi && match_hi) : 1'b0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_lo <= 1'b0;
      done_hi <= 1'b0;
    end else begin
      // rewriting control rearms a one-time run
      if (ev_lo && timer_control_low[`GPTCP_B_RUN +: 2] == gptcp_pkg::GPTCP_RUN_ONCE) begin
        done_lo <= 1'b1;
      end else if (wr && wb_adr_i == `GPTCP_OFS_CTLL) begin
        done_lo <= 1'b0;
      end
      if (ev_hi && ctl_hi_eff[`GPTCP_B_RUN +: 2] == gptcp_pkg::GPTCP_RUN_ONCE) begin
        done_hi <= 1'b1;
      end else if (wr && (wb_adr_i == `GPTCP_OFS_CTLH || wb_adr_i == `GPTCP_OFS_CTLL)) begin
        done_hi <= 1'b0;
      end
    end
  end

  // ****************************************
  // period and control words
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        period_word[i] <= 16'h0000;
      end
      timer_control_low <= `GPTCP_CTL_RST;
      timer_control_high <= `GPTCP_CTL_RST;
      global_control_word <= `GPTCP_GLB_RST;
    end else if (wr) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_adr_i == (`GPTCP_OFS_PERIOD0 + 8'(4 * i))) begin
          period_word[i] <= wb_dat_i[15:0];
        end
      end
      // reserved and status bits ignore writes
      if (wb_adr_i == `GPTCP_OFS_CTLL) begin
        timer_control_low <= wb_dat_i[15:0] & `GPTCP_CTL_WMASK;
      end
      if (wb_adr_i == `GPTCP_OFS_CTLH) begin
        timer_control_high <= wb_dat_i[15:0] & `GPTCP_CTL_WMASK;
      end
      if (wb_adr_i == `GPTCP_OFS_GLB) begin
        global_control_word <= {12'h000, wb_dat_i[3:0]};
      end
    end
  end

  // ****************************************
  // output generation
  // ****************************************
  logic style_lo;
  logic style_hi;
  assign style_lo = timer_control_low[`GPTCP_B_STYLE] && (opmode != gptcp_pkg::GPTCP_MODE_WDOG);
  assign style_hi = ctl_hi_eff[`GPTCP_B_STYLE];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_lo <= 1'b0;
      pw_lo <= 3'h0;
    end else if (!lower_half_run_bit) begin
      stat_lo <= 1'b0;
      pw_lo <= 3'h0;
    end else if (!gpio_use_i) begin
      // frozen while gpio owns the pin
      if (style_lo) begin
        if (ev_lo) begin
          stat_lo <= !stat_lo;
        end
      end else if (ev_lo) begin
        stat_lo <= 1'b1;
        // width of one to four ticks
        pw_lo <= {1'b0, timer_control_low[`GPTCP_B_PULSE_WIDTH +: 2]};
      end else if (stat_lo && tick_lo) begin
        if (pw_lo == 3'h0) begin
          stat_lo <= 1'b0;
        end else begin
          pw_lo <= pw_lo - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !upper_half_run_bit) begin
      stat_hi <= 1'b0;
      pw_hi <= 3'h0;
    end else if (!gpio_use_i) begin
      if (style_hi) begin
        if (ev_hi) begin
          stat_hi <= !stat_hi;
        end
      end else if (ev_hi) begin
        stat_hi <= 1'b1;
        pw_hi <= {1'b0, ctl_hi_eff[`GPTCP_B_PULSE_WIDTH +: 2]};
      end else if (stat_hi && carry_hi) begin
        if (pw_hi == 3'h0) begin
          stat_hi <= 1'b0;
        end else begin
          pw_hi <= pw_hi - 3'h1;
        end
      end
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_out_o <= 1'b0;
      tmr_oe_o <= 1'b0;
    end else begin
      tmr_out_o <= stat_lo ^ timer_control_low[`GPTCP_B_INV_OUT];
      // float while lower half in reset
      tmr_oe_o <= lower_half_run_bit && !gpio_use_i;
    end
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      // unmapped addresses read zero and writes there are dropped
      unique case (wb_adr_i)
        `GPTCP_OFS_COUNT0: wb_dat_o <= {16'h0000, count_word[0]};
        `GPTCP_OFS_COUNT1: wb_dat_o <= {16'h0000, count_word[1]};
        `GPTCP_OFS_COUNT2: wb_dat_o <= {16'h0000, count_word[2]};
        `GPTCP_OFS_COUNT3: wb_dat_o <= {16'h0000, count_word[3]};
        `GPTCP_OFS_PERIOD0: wb_dat_o <= {16'h0000, period_word[0]};
        `GPTCP_OFS_PERIOD1: wb_dat_o <= {16'h0000, period_word[1]};
        `GPTCP_OFS_PERIOD2: wb_dat_o <= {16'h0000, period_word[2]};
        `GPTCP_OFS_PERIOD3: wb_dat_o <= {16'h0000, period_word[3]};
        `GPTCP_OFS_CTLL: wb_dat_o <= {16'h0000, timer_control_low[15:1], stat_lo};
        `GPTCP_OFS_CTLH: wb_dat_o <= {16'h0000, timer_control_high[15:1], stat_hi};
        `GPTCP_OFS_GLB: wb_dat_o <= {16'h0000, global_control_word};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_wrap64;
    adv64 && match64 && !wr;
  endsequence

  count_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wrap64 |=> cnt64 == 64'h0) else $error("count did not wrap to zero");
  count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    adv64 && !match64 && !wr |=> cnt64 == $past(cnt64) + 64'h1) else $error("count did not step");
  count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_control_low[7:6] == 2'b00 && !dual && !wr |=> $stable(cnt64)) else $error("disabled count moved");
  half_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !lower_half_run_bit && !wr |=> $stable({count_word[1], count_word[0]})) else $error("low pair moved");
  ctl_resv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_control_low[15:10] == 6'h00 && timer_control_high[15:10] == 6'h00) else $error("reserved bits set");
  stat_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !lower_half_run_bit |=> !stat_lo && !tmr_oe_o) else $error("status not cleared");
  toggle_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lower_half_run_bit && style_lo && ev_lo && !gpio_use_i |=> stat_lo != $past(stat_lo)) else $error("no toggle");
  pulse_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lower_half_run_bit && !style_lo && ev_lo && !gpio_use_i |=> stat_lo) else $error("no pulse");
  out_inv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> tmr_out_o == ($past(stat_lo) ^ $past(timer_control_low[1]))) else $error("output polarity wrong");
  gpio_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    gpio_use_i && lower_half_run_bit |=> $stable(stat_lo)) else $error("status changed in gpio use");
endmodule : gptcp_timer

//--- logic/gptcp_map.svh
// register offsets, field positions and reset values of the timer
// assumes a wishbone slave with 32-bit words, one register per aligned word
`ifndef GPTCP_MAP_SVH
`define GPTCP_MAP_SVH
`define GPTCP_OFS_COUNT0 8'h00
`define GPTCP_OFS_COUNT1 8'h04
`define GPTCP_OFS_COUNT2 8'h08
`define GPTCP_OFS_COUNT3 8'h0C
`define GPTCP_OFS_PERIOD0 8'h10
`define GPTCP_OFS_PERIOD1 8'h14
`define GPTCP_OFS_PERIOD2 8'h18
`define GPTCP_OFS_PERIOD3 8'h1C
`define GPTCP_OFS_CTLL 8'h20
`define GPTCP_OFS_CTLH 8'h24
`define GPTCP_OFS_GLB 8'h28
`define GPTCP_CTL_WMASK 16'h03FE
`define GPTCP_CTL_RST 16'h0000
`define GPTCP_GLB_RST 16'h0000
`define GPTCP_B_GATE 9
`define GPTCP_B_CSRC 8
`define GPTCP_B_RUN 6
`define GPTCP_B_PULSE_WIDTH 4
`define GPTCP_B_STYLE 3
`define GPTCP_B_INV_IN 2
`define GPTCP_B_INV_OUT 1
`define GPTCP_B_STAT 0
`define GPTCP_B_MODE 2
`define GPTCP_B_URUN 1
`define GPTCP_B_LRUN 0
`define GPTCP_B_GPIO 4
`endif

//--- logic/gptcp_pkg.sv
// types of the timer count, period and control block
// assumes gptcp_map.svh carries the numeric constants
package gptcp_pkg;
  typedef enum logic [1:0] {
    GPTCP_RUN_OFF = 2'b00,
    GPTCP_RUN_ONCE = 2'b01,
    GPTCP_RUN_CONT = 2'b10,
    GPTCP_RUN_RSVD = 2'b11
  } gptcp_run_t;
  typedef enum logic [1:0] {
    GPTCP_MODE_GP64 = 2'b00,
    GPTCP_MODE_DUAL_IND = 2'b01,
    GPTCP_MODE_WDOG = 2'b10,
    GPTCP_MODE_DUAL_CHN = 2'b11
  } gptcp_mode_t;
endpackage : gptcp_pkg

//--- tb/gptcp_pin_model.sv
// far-side model of the timer: drives the timer pin and the gate input
// assumes the bench calls its tasks from the clk_i domain, one at a time
`timescale 1ns/1ns
module gptcp_pin_model (
  input wire logic clk_i,
  output logic tmr_pin_o,
  output logic gate_pin_o
);
  // both lines idle low outside a burst, like a source that is not clocking
  initial begin
    tmr_pin_o = 1'b0;
    gate_pin_o = 1'b0;
  end

  // each level is held 3 cycles, above the 2-cycle minimum the synchronizer needs
  task pulse(input int n, input logic idle);
    repeat (n) begin
      @(posedge clk_i);
      tmr_pin_o <= ~idle;
      repeat (3) @(posedge clk_i);
      tmr_pin_o <= idle;
      repeat (2) @(posedge clk_i);
    end
  endtask : pulse

  task set_pin(input logic lvl);
    @(posedge clk_i);
    tmr_pin_o <= lvl;
  endtask : set_pin

  task gate_for(input int n);
    @(posedge clk_i);
    gate_pin_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    gate_pin_o <= 1'b0;
  endtask : gate_for
endmodule : gptcp_pin_model

//--- tb/gptcp_timer_tb.sv
// self-checking bench of the timer: wishbone master tasks and one task per scenario
// assumes the pin model drives the timer pin and gate input
`timescale 1ns/1ns
`include "gptcp_map.svh"
module gptcp_timer_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic tmr_pin_i;
  logic gate_pin_i;
  logic gpio_use_i = 1'b0;
  logic tmr_out_o;
  logic tmr_oe_o;
  logic [15:0] rd;
  int errors = 0;
  int n_compared = 0;
  // table of output scenarios: control word, global word, settle wait, high cycles in 40 (in 60 for the one-time entry)
  logic [15:0] ctl_tab [9] = '{16'h0080, 16'h0090, 16'h00A0, 16'h00B0, 16'h0092, 16'h0088, 16'h0088,
    16'h0040, 16'h0000};
  logic [15:0] glb_tab [9] = '{16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h000B,
    16'h0003, 16'h0003};
  int wt_tab [9] = '{20, 20, 20, 20, 20, 20, 20, 0, 0};
  int exp_tab [9] = '{4, 8, 12, 16, 32, 20, 4, 1, 0};

  always #10 clk_i = ~clk_i;

  gptcp_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tmr_pin_i(tmr_pin_i), .gate_pin_i(gate_pin_i),
    .gpio_use_i(gpio_use_i), .tmr_out_o(tmr_out_o), .tmr_oe_o(tmr_oe_o));

  gptcp_pin_model u_pin (.clk_i(clk_i), .tmr_pin_o(tmr_pin_i), .gate_pin_o(gate_pin_i));

  // ******************************
  // bus and checking helpers
  // ******************************
  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // the request stands until ack is seen; the bound only catches a dead slave
  task wb(input logic we, input logic [7:0] adr, input logic [15:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0000, wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      errors++;
      $display("unexpected bus_ack expected 1 seen 0");
      end_sim();
    end
  endtask : wb

  task hw_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : hw_reset

  // counts stopped before the period words change so no stale count runs away
  task setup(input logic [15:0] ctl, input logic [15:0] glb, input logic [15:0] p0, input logic [15:0] p2);
    wb(1'b1, `GPTCP_OFS_CTLL, 16'h0000);
    wb(1'b1, `GPTCP_OFS_CTLH, 16'h0000);
    wb(1'b1, `GPTCP_OFS_GLB, glb);
    for (int i = 0; i < 8; i++) wb(1'b1, 8'(4 * i), (i == 4) ? p0 : (i == 6) ? p2 : 16'h0000);
    wb(1'b1, `GPTCP_OFS_CTLL, ctl);
  endtask : setup

  // ******************************
  // scenarios
  // ******************************
  task t_reset_values;
    for (int i = 0; i < 12; i++) begin
      wb(1'b0, 8'(4 * i), 16'h0000);
      chk("reset_word", 16'h0000, rd);
    end
    chk("oe_in_reset", 16'h0000, {15'h0000, tmr_oe_o});
  endtask : t_reset_values

  task t_regs;
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, 8'(4 * i), 16'hFFFF);
      wb(1'b0, 8'(4 * i), 16'h0000);
      chk("word_rw", 16'hFFFF, rd);
    end
    for (int i = 8; i < 10; i++) begin
      wb(1'b1, 8'(4 * i), 16'hFFFF);
      wb(1'b0, 8'(4 * i), 16'h0000);
      chk("ctl_rw", 16'h03FE, rd);
    end
    wb(1'b1, `GPTCP_OFS_CTLL, 16'h0080);
    repeat (10) @(posedge clk_i);
    wb(1'b0, `GPTCP_OFS_COUNT0, 16'h0000);
    chk("held_count", 16'hFFFF, rd);
    hw_reset();
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'(4 * i), 16'h0000);
      chk("count_after_reset", 16'h0000, rd);
    end
  endtask : t_regs

  // period 9 gives 10 ticks per cycle, so 40 cycles hold exactly four periods
  task t_output;
    int h;
    for (int k = 0; k < 9; k++) begin
      setup(ctl_tab[k], glb_tab[k], 16'h0009, 16'h0000);
      repeat (wt_tab[k]) @(posedge clk_i);
      h = 0;
      repeat ((k == 7) ? 60 : 40) begin
        @(posedge clk_i);
        if (tmr_out_o === 1'b1) h++;
      end
      chk("out_high_cycles", 16'(exp_tab[k]), 16'(h));
    end
  endtask : t_output

  task t_pin;
    setup(16'h0180, 16'h0003, 16'hFFFF, 16'h0000);
    repeat (20) @(posedge clk_i);
    u_pin.pulse(3, 1'b0);
    repeat (6) @(posedge clk_i);
    wb(1'b0, `GPTCP_OFS_COUNT0, 16'h0000);
    chk("pin_ticks", 16'h0003, rd);
    u_pin.set_pin(1'b1);
    setup(16'h0184, 16'h0003, 16'hFFFF, 16'h0000);
    u_pin.pulse(3, 1'b1);
    repeat (6) @(posedge clk_i);
    wb(1'b0, `GPTCP_OFS_COUNT0, 16'h0000);
    chk("inverted_pin_ticks", 16'h0003, rd);
    u_pin.set_pin(1'b0);
  endtask : t_pin

  task t_gate;
    setup(16'h0280, 16'h0003, 16'hFFFF, 16'h0000);
    repeat (10) @(posedge clk_i);
    u_pin.gate_for(12);
    repeat (6) @(posedge clk_i);
    wb(1'b0, `GPTCP_OFS_COUNT0, 16'h0000);
    chk("gated_ticks", 16'h000C, rd);
  endtask : t_gate

  task t_dual;
    setup(16'h0000, 16'h0007, 16'hFFFF, 16'hFFFF);
    wb(1'b1, `GPTCP_OFS_CTLH, 16'h0080);
    repeat (20) @(posedge clk_i);
    wb(1'b1, `GPTCP_OFS_CTLH, 16'h0000);
    wb(1'b0, `GPTCP_OFS_COUNT0, 16'h0000);
    chk("low_pair_idle", 16'h0000, rd);
    // run window spans 23 ticks: from the edge after the start write to the stop write
    wb(1'b0, `GPTCP_OFS_COUNT2, 16'h0000);
    chk("high_pair_count", 16'h0017, rd);
    // chained: low period 4 prescales, so 23 ticks leave 4 high steps and a low remainder of 3
    setup(16'h0080, 16'h000F, 16'h0004, 16'hFFFF);
    repeat (20) @(posedge clk_i);
    wb(1'b1, `GPTCP_OFS_CTLL, 16'h0000);
    wb(1'b0, `GPTCP_OFS_COUNT2, 16'h0000);
    chk("chained_high_pair", 16'h0004, rd);
    wb(1'b0, `GPTCP_OFS_COUNT0, 16'h0000);
    chk("chained_low_pair", 16'h0003, rd);
    setup(16'h0000, 16'h0003, 16'hFFFF, 16'hFFFF);
    wb(1'b1, `GPTCP_OFS_CTLH, 16'h0080);
    repeat (20) @(posedge clk_i);
    wb(1'b0, `GPTCP_OFS_COUNT2, 16'h0000);
    chk("ctlh_ignored", 16'h0000, rd);
    wb(1'b1, `GPTCP_OFS_CTLH, 16'h0000);
  endtask : t_dual

  task t_gpio;
    logic [15:0] s;
    setup(16'h0088, 16'h0003, 16'h0004, 16'h0000);
    repeat (10) @(posedge clk_i);
    chk("oe_running", 16'h0001, {15'h0000, tmr_oe_o});
    gpio_use_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    wb(1'b0, `GPTCP_OFS_CTLL, 16'h0000);
    s = rd;
    repeat (7) @(posedge clk_i);
    wb(1'b0, `GPTCP_OFS_CTLL, 16'h0000);
    chk("frozen_status", s, rd);
    chk("oe_in_gpio", 16'h0000, {15'h0000, tmr_oe_o});
    gpio_use_i <= 1'b0;
  endtask : t_gpio

  initial begin
    hw_reset();
    t_reset_values();
    t_regs();
    t_output();
    t_pin();
    t_gate();
    t_dual();
    t_gpio();
    end_sim();
  end
endmodule : gptcp_timer_tb
